// ===== src/code_stepper.sv
`timescale 1ns/1ps
`default_nettype none
`include "glide_map.svh"
module code_stepper (
  input  wire logic                 i_mclk,
  input  wire logic                 i_sys_rst,
  input  wire logic                 i_clear,
  input  wire logic                 i_load,
  input  wire logic                 i_glide,
  input  wire logic                 i_step,
  input  wire glide_pkg::key_code_t i_target,
  output var glide_pkg::key_code_t  o_code,
  output logic                      o_busy,
  output logic                      o_done
);
  glide_pkg::step_state_t state;
  glide_pkg::step_dir_t   dir;
  glide_pkg::key_code_t   goal;
  glide_pkg::key_code_t   next_code;

  ////////////////////////////////////////////////////////////////////////////
  // Step size: two across a code ending in 00, one otherwise.
  always_comb begin
    if (dir == glide_pkg::DIR_UP) begin
      next_code = (o_code[1:0] == `LOW_JUMP_UP) ? o_code + `STEP_TWO
                                                : o_code + `STEP_ONE;
    end else begin
      next_code = (o_code[1:0] == `LOW_JUMP_DN) ? o_code - `STEP_TWO
                                                : o_code - `STEP_ONE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state  <= glide_pkg::ST_IDLE;
      dir    <= glide_pkg::DIR_UP;
      goal   <= '0;
      o_code <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_clear) begin
        o_code <= i_target;
        goal   <= i_target;
        state  <= glide_pkg::ST_IDLE;
      end else if (i_load && !i_glide) begin
        o_code <= i_target;
        goal   <= i_target;
        state  <= glide_pkg::ST_IDLE;
      end else if (i_load && (i_target != o_code)) begin
        goal  <= i_target;
        dir   <= (i_target > o_code) ? glide_pkg::DIR_UP : glide_pkg::DIR_DOWN;
        state <= glide_pkg::ST_RUN;
      end else begin
        unique case (state)
          glide_pkg::ST_IDLE: begin
            state <= glide_pkg::ST_IDLE;
          end
          glide_pkg::ST_RUN: begin
            if (o_code == goal) begin
              state  <= glide_pkg::ST_IDLE;
              o_done <= 1'b1;
            end else if (i_step) begin
              o_code <= next_code;
            end
          end
          default: begin
            state <= glide_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  assign o_busy = (state == glide_pkg::ST_RUN);
endmodule : code_stepper
`default_nettype wire

// ===== src/glide_map.svh
`ifndef GLIDE_MAP_SVH
`define GLIDE_MAP_SVH
`define CODE_W        7
`define SEMI_W        4
`define NOTE_W        3
`define SEMI_LINES    9
`define NOTE_LINES    7
`define OCT_TAPS      8
`define NOTE_TAPS     6
`define SYNC_STAGES   3
`define PORTA_SEMI    4'h8
`define MONO_SEMI     4'h7
`define GLIDE_SEMI    4'h9
`define NOTE_ZERO     3'h0
`define NOTE_UNUSED   3'h4
`define LOW_NONPITCH  2'h0
`define LOW_JUMP_UP   2'h3
`define LOW_JUMP_DN   2'h1
`define STEP_ONE      7'h01
`define STEP_TWO      7'h02
`endif

// ===== src/glide_pkg.sv
package glide_pkg;
  typedef logic [6:0] key_code_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } step_state_t;
  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } step_dir_t;
endpackage : glide_pkg

// ===== src/glissando_key_code_stepper.sv
`timescale 1ns/1ps
`default_nettype none
`include "glide_map.svh"
// Notes on behaviour
// - Codes with low two bits 00 are never pitches; note value four unused.
// - Note block A/D-sharp encodes as 3, A-sharp/E as 5.
// - Zero note with line eight is portamento; next-lower line is mono pair.
// - Zero note with glide line toggles glissando processing.
// - Under glissando a new code sets direction from comparison with stored code.
// - Stored code steps until equal to the new code, then stops and marks done.
// - Down from 01 subtracts two, up from 11 adds two, otherwise one.
// - One step per period of the glide step clock.
// - At most one octave tap and one note tap follow the current code.
// - Upper and lower channels share the tap decoder by time slots.
// - Hold gate control one passes key voltage, zero holds it.
// - Keyed hold setting opens a channel gate only during its key-on.
// - Open hold setting keeps both gates open continuously.
module glissando_key_code_stepper (
  input  wire logic                   i_mclk,
  input  wire logic                   i_sys_rst,
  input  wire logic [`SEMI_LINES:1]   i_semi_octave_line,
  input  wire logic [`NOTE_LINES-1:0] i_note_line,
  input  wire logic                   i_glide_step_clock,
  input  wire logic                   i_initial_clear,
  input  wire logic                   i_assign_lower,
  input  wire logic                   i_upper_key_on,
  input  wire logic                   i_lower_key_on,
  input  wire logic                   i_open_hold_setting,
  output logic [`CODE_W-1:0]          o_upper_code,
  output logic [`CODE_W-1:0]          o_lower_code,
  output logic [`OCT_TAPS-1:0]        o_upper_octave_tap,
  output logic [`NOTE_TAPS-1:0]       o_upper_note_tap,
  output logic [`OCT_TAPS-1:0]        o_lower_octave_tap,
  output logic [`NOTE_TAPS-1:0]       o_lower_note_tap,
  output logic                        o_upper_hold_gate,
  output logic                        o_lower_hold_gate,
  output logic                        o_glide_active,
  output logic                        o_portamento_on,
  output logic                        o_mono_pair,
  output logic                        o_glide_busy,
  output logic                        o_glide_done
);
  key_code_if kc ();

  glide_pkg::key_code_t prev_code;
  glide_pkg::key_code_t upper_cur;
  glide_pkg::key_code_t lower_cur;
  glide_pkg::key_code_t slot_code;
  logic                 prev_pitch;
  logic                 new_key;
  logic                 load_upper;
  logic                 load_lower;
  logic                 upper_busy;
  logic                 lower_busy;
  logic                 upper_done;
  logic                 lower_done;
  logic                 porta_prev;
  logic                 mono_prev;
  logic                 glide_prev;
  logic                 slot;
  logic [`OCT_TAPS-1:0]  oct_dec;
  logic [`NOTE_TAPS-1:0] note_dec;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronising and encoding.
  key_encoder u_encoder (
    .i_mclk             (i_mclk),
    .i_sys_rst          (i_sys_rst),
    .i_semi_octave_line (i_semi_octave_line),
    .i_note_line        (i_note_line),
    .i_glide_step_clock (i_glide_step_clock),
    .i_initial_clear    (i_initial_clear),
    .kc                 (kc.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // New pitch detection and routing to the assigned channel.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prev_code  <= '0;
      prev_pitch <= 1'b0;
    end else begin
      prev_code  <= kc.code;
      prev_pitch <= kc.is_pitch;
    end
  end

  assign new_key    = kc.is_pitch && (!prev_pitch || (kc.code != prev_code));
  assign load_upper = new_key && !i_assign_lower;
  assign load_lower = new_key && i_assign_lower;

  ////////////////////////////////////////////////////////////////////////////
  // Function code toggles, each acting on the rising edge of its key.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      porta_prev <= 1'b0;
      mono_prev  <= 1'b0;
      glide_prev <= 1'b0;
    end else begin
      porta_prev <= kc.porta_key;
      mono_prev  <= kc.mono_key;
      glide_prev <= kc.glide_key;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_portamento_on <= 1'b0;
      o_mono_pair     <= 1'b0;
      o_glide_active  <= 1'b0;
    end else begin
      if (kc.porta_key && !porta_prev) begin
        o_portamento_on <= !o_portamento_on;
      end
      if (kc.mono_key && !mono_prev) begin
        o_mono_pair <= !o_mono_pair;
      end
      if (kc.glide_key && !glide_prev) begin
        o_glide_active <= !o_glide_active;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One stepper per channel.
  code_stepper u_upper (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (kc.init_clear),
    .i_load    (load_upper),
    .i_glide   (o_glide_active),
    .i_step    (kc.step_pulse),
    .i_target  (kc.code),
    .o_code    (upper_cur),
    .o_busy    (upper_busy),
    .o_done    (upper_done)
  );

  code_stepper u_lower (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (kc.init_clear),
    .i_load    (load_lower),
    .i_glide   (o_glide_active),
    .i_step    (kc.step_pulse),
    .i_target  (kc.code),
    .o_code    (lower_cur),
    .o_busy    (lower_busy),
    .o_done    (lower_done)
  );

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_glide_busy <= 1'b0;
      o_glide_done <= 1'b0;
    end else begin
      o_glide_busy <= upper_busy || lower_busy;
      o_glide_done <= upper_done || lower_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tap decoder; slot zero serves the upper channel, slot one the lower.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      slot <= 1'b0;
    end else begin
      slot <= !slot;
    end
  end

  assign slot_code = slot ? lower_cur : upper_cur;

  always_comb begin
    oct_dec  = '0;
    note_dec = '0;
    for (int k = 1; k <= `OCT_TAPS; k++) begin
      if (slot_code[`CODE_W-1:`NOTE_W] == k[`SEMI_W-1:0]) begin
        oct_dec[k-1] = slot_code[1:0] != `LOW_NONPITCH;
      end
    end
    for (int n = 1; n <= `NOTE_TAPS; n++) begin
      if (slot_code[`NOTE_W-1:0] == ((n >= 4) ? 3'(n + 1) : 3'(n))) begin
        note_dec[n-1] = slot_code[`CODE_W-1:`NOTE_W] != '0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_upper_code       <= '0;
      o_lower_code       <= '0;
      o_upper_octave_tap <= '0;
      o_upper_note_tap   <= '0;
      o_lower_octave_tap <= '0;
      o_lower_note_tap   <= '0;
    end else if (slot) begin
      o_lower_code       <= slot_code;
      o_lower_octave_tap <= oct_dec;
      o_lower_note_tap   <= note_dec;
    end else begin
      o_upper_code       <= slot_code;
      o_upper_octave_tap <= oct_dec;
      o_upper_note_tap   <= note_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold gate controls; one passes the key voltage, zero holds it.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_upper_hold_gate <= 1'b0;
      o_lower_hold_gate <= 1'b0;
    end else if (i_open_hold_setting) begin
      o_upper_hold_gate <= 1'b1;
      o_lower_hold_gate <= 1'b1;
    end else begin
      o_upper_hold_gate <= i_upper_key_on;
      o_lower_hold_gate <= i_lower_key_on;
    end
  end
endmodule : glissando_key_code_stepper
`default_nettype wire

// ===== src/key_code_if.sv
`timescale 1ns/1ps
`default_nettype none
interface key_code_if;
  glide_pkg::key_code_t code;
  logic                 is_pitch;
  logic                 porta_key;
  logic                 mono_key;
  logic                 glide_key;
  logic                 init_clear;
  logic                 step_pulse;
  modport src (output code, is_pitch, porta_key, mono_key, glide_key, init_clear, step_pulse);
  modport snk (input code, is_pitch, porta_key, mono_key, glide_key, init_clear, step_pulse);
endinterface : key_code_if
`default_nettype wire

// ===== src/key_encoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "glide_map.svh"
module key_encoder (
  input  wire logic                       i_mclk,
  input  wire logic                       i_sys_rst,
  input  wire logic [`SEMI_LINES:1]       i_semi_octave_line,
  input  wire logic [`NOTE_LINES-1:0]     i_note_line,
  input  wire logic                       i_glide_step_clock,
  input  wire logic                       i_initial_clear,
  key_code_if.src                         kc
);
  localparam int W = `SEMI_LINES + `NOTE_LINES + 2;

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] filt;
  logic         clk_prev;
  logic [`SEMI_W-1:0] semi;
  logic [`NOTE_W-1:0] note;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser; a bit changes once stages two and three agree.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      filt <= '0;
    end else begin
      s1 <= {i_initial_clear, i_glide_step_clock, i_note_line, i_semi_octave_line};
      s2 <= s1;
      s3 <= s2;
      for (int b = 0; b < W; b++) begin
        if (s2[b] == s3[b]) begin
          filt[b] <= s3[b];
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= filt[W-2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line-to-binary encoding; note line four encodes as five so four is unused.
  always_comb begin
    semi = '0;
    note = `NOTE_ZERO;
    for (int k = 1; k <= `SEMI_LINES; k++) begin
      if (filt[k-1]) begin
        semi = k[`SEMI_W-1:0];
      end
    end
    for (int n = 1; n < `NOTE_LINES; n++) begin
      if (filt[`SEMI_LINES+n]) begin
        note = (n >= 4) ? 3'(n + 1) : 3'(n);
      end
    end
  end

  assign kc.code       = {semi, note};
  assign kc.is_pitch   = (semi != '0) && (note[1:0] != `LOW_NONPITCH);
  assign kc.porta_key  = (semi == `PORTA_SEMI) && filt[`SEMI_LINES];
  assign kc.mono_key   = (semi == `MONO_SEMI) && filt[`SEMI_LINES];
  assign kc.glide_key  = (semi == `GLIDE_SEMI) && filt[`SEMI_LINES];
  assign kc.init_clear = filt[W-1];
  assign kc.step_pulse = filt[W-2] && !clk_prev;
endmodule : key_encoder
`default_nettype wire

// ===== testbench/glissando_key_code_stepper_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "glide_map.svh"
module glissando_key_code_stepper_chk (
  input wire logic                   i_mclk,
  input wire logic                   i_sys_rst,
  input wire logic                   i_upper_key_on,
  input wire logic                   i_lower_key_on,
  input wire logic                   i_open_hold_setting,
  input wire logic [`CODE_W-1:0]     o_upper_code,
  input wire logic [`CODE_W-1:0]     o_lower_code,
  input wire logic [`OCT_TAPS-1:0]   o_upper_octave_tap,
  input wire logic [`NOTE_TAPS-1:0]  o_upper_note_tap,
  input wire logic                   o_upper_hold_gate,
  input wire logic                   o_lower_hold_gate,
  input wire logic                   o_glide_busy,
  input wire logic                   o_glide_done,
  input wire logic                   o_portamento_on
);
  logic [1:0] warm;
  logic [1:0] held;
  logic [6:0] prev_up;
  logic [6:0] delta;
  logic [2:0] nsel;
  logic       pitch;
  assign delta = o_upper_code - prev_up;
  assign nsel  = (o_upper_code[2:0] > 3'h4) ? o_upper_code[2:0] - 3'h2 : o_upper_code[2:0] - 3'h1;
  assign pitch = o_upper_code[1:0] != 2'h0 && o_upper_code[6:3] inside {[4'h1:4'h8]};
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) warm <= 2'h0;
    else if (warm != 2'h3) warm <= warm + 2'h1;
  end
  always_ff @(posedge i_mclk) begin
    prev_up <= o_upper_code;
    if (i_sys_rst || o_upper_code != prev_up) held <= 2'h0;
    else if (held != 2'h3) held <= held + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  chk_no_note_four: assert property (
    o_upper_code[2:0] != 3'h4 && o_lower_code[2:0] != 3'h4)
    else $error("note field four on a channel code");
  chk_octave_onehot: assert property ($onehot0(o_upper_octave_tap))
    else $error("more than one octave tap enabled");
  chk_octave_match: assert property (
    held == 2'h3 && pitch |-> o_upper_octave_tap == (8'h01 << (o_upper_code[6:3] - 4'h1)))
    else $error("octave tap does not follow upper code");
  chk_note_match: assert property (
    held == 2'h3 && pitch |-> o_upper_note_tap == (6'h01 << nsel))
    else $error("note tap does not follow upper code");
  chk_hold_open: assert property (
    warm == 2'h3 && i_open_hold_setting |=> o_upper_hold_gate && o_lower_hold_gate)
    else $error("open hold setting left a gate closed");
  chk_hold_keyed: assert property (
    warm == 2'h3 && !i_open_hold_setting |=> o_upper_hold_gate == $past(i_upper_key_on)
      && o_lower_hold_gate == $past(i_lower_key_on))
    else $error("keyed hold gate does not follow key-on");
  chk_done_after: assert property (
    warm == 2'h3 && o_glide_done |-> !o_glide_busy && $past(o_glide_busy))
    else $error("done pulse not right after busy ended");
  chk_done_single: assert property (o_glide_done |=> !o_glide_done)
    else $error("done pulse longer than one cycle");
  chk_step_size: assert property (
    warm == 2'h3 && o_glide_busy && $past(o_glide_busy) && $past(o_glide_busy, 2)
      && o_upper_code != prev_up |-> delta inside {7'h01, 7'h02, 7'h7e, 7'h7f})
    else $error("glide step is not one or two");
  cov_done: cover property (o_glide_done);
  cov_porta: cover property (o_portamento_on);
  cov_open: cover property (i_open_hold_setting && o_lower_hold_gate);
endmodule : glissando_key_code_stepper_chk
`default_nettype wire

// ===== testbench/key_matrix_model.sv
`timescale 1ns/1ps
`default_nettype none
module key_matrix_model (
  input  wire logic       i_press,
  input  wire logic [3:0] i_semi,
  input  wire logic [2:0] i_note,
  output logic [9:1]      o_semi_octave_line,
  output logic [6:0]      o_note_line
);
  // A released key leaves every line at its pull-down level.
  always_comb begin
    o_semi_octave_line = 9'h000;
    o_note_line        = 7'h00;
    if (i_press) begin
      o_semi_octave_line[i_semi] = 1'b1;
      o_note_line[(i_note > 3'h4) ? i_note - 3'h1 : i_note] = 1'b1;
    end
  end
endmodule : key_matrix_model
`default_nettype wire

// ===== testbench/tb_glissando_key_code_stepper.sv
`timescale 1ns/1ps
`default_nettype none
module tb_glissando_key_code_stepper;
  logic       i_mclk    = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       press     = 1'b0;
  logic [3:0] semi      = 4'h0;
  logic [2:0] note      = 3'h0;
  logic       step_clk  = 1'b0;
  logic       clear     = 1'b0;
  logic       to_lower  = 1'b0;
  logic       up_on     = 1'b0;
  logic       lo_on     = 1'b0;
  logic       open_hold = 1'b0;
  logic [9:1] semi_line;
  logic [6:0] note_line, up_code, lo_code;
  logic [7:0] up_oct, lo_oct;
  logic [5:0] up_note, lo_note;
  logic       up_gate, lo_gate, glide_on, porta, mono, busy, done;
  int         fail_count = 0;
  int         cmp_count  = 0;
  int         done_count = 0;
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (done === 1'b1) done_count++;
  key_matrix_model partner (.i_press(press), .i_semi(semi), .i_note(note),
    .o_semi_octave_line(semi_line), .o_note_line(note_line));
  glissando_key_code_stepper dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_semi_octave_line(semi_line),
    .i_note_line(note_line), .i_glide_step_clock(step_clk), .i_initial_clear(clear),
    .i_assign_lower(to_lower), .i_upper_key_on(up_on), .i_lower_key_on(lo_on),
    .i_open_hold_setting(open_hold), .o_upper_code(up_code), .o_lower_code(lo_code),
    .o_upper_octave_tap(up_oct), .o_upper_note_tap(up_note), .o_lower_octave_tap(lo_oct),
    .o_lower_note_tap(lo_note), .o_upper_hold_gate(up_gate), .o_lower_hold_gate(lo_gate),
    .o_glide_active(glide_on), .o_portamento_on(porta), .o_mono_pair(mono),
    .o_glide_busy(busy), .o_glide_done(done));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic key(input logic [3:0] s, input logic [2:0] n, input logic p);
    @(posedge i_mclk);
    semi  <= s;
    note  <= n;
    press <= p;
    repeat (10) @(posedge i_mclk);
  endtask : key
  task automatic pulse();
    @(posedge i_mclk) step_clk <= 1'b1;
    repeat (8) @(posedge i_mclk);
    step_clk <= 1'b0;
    repeat (8) @(posedge i_mclk);
  endtask : pulse
  function automatic logic [7:0] tap_oct(input logic [6:0] c);
    return 8'h01 << (c[6:3] - 4'h1);
  endfunction : tap_oct
  function automatic logic [5:0] tap_note(input logic [6:0] c);
    return 6'h01 << ((c[2:0] > 3'h4) ? c[2:0] - 3'h2 : c[2:0] - 3'h1);
  endfunction : tap_note
  function automatic logic [6:0] next_code(input logic [6:0] c, input logic up);
    if (up) return c + ((c[1:0] == 2'h3) ? 7'h02 : 7'h01);
    return c - ((c[1:0] == 2'h1) ? 7'h02 : 7'h01);
  endfunction : next_code
  task automatic glide(input logic [6:0] from, input logic [6:0] to);
    logic [6:0] exp;
    exp = from;
    while (exp != to) begin
      pulse();
      exp = next_code(exp, to > from);
      chk(up_code, exp);
    end
    repeat (6) @(posedge i_mclk);
    chk(busy, 1'b0);
  endtask : glide
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    up_on     <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk(up_gate, 1'b1);
    chk(lo_gate, 1'b0);
    open_hold <= 1'b1;
    repeat (4) @(posedge i_mclk);
    chk(lo_gate, 1'b1);
    key(4'h3, 3'h5, 1'b1);
    chk(up_code, 7'h1d);
    chk(up_oct, tap_oct(7'h1d));
    chk(up_note, tap_note(7'h1d));
    to_lower <= 1'b1;
    key(4'h5, 3'h1, 1'b1);
    chk(lo_code, 7'h29);
    chk(lo_oct, tap_oct(7'h29));
    chk(lo_note, tap_note(7'h29));
    chk(up_code, 7'h1d);
    key(4'h2, 3'h0, 1'b1);
    chk(lo_code, 7'h29);
    key(4'h0, 3'h0, 1'b0);
    key(4'h8, 3'h0, 1'b1);
    key(4'h7, 3'h0, 1'b1);
    key(4'h9, 3'h0, 1'b1);
    chk(porta, 1'b1);
    chk(mono, 1'b1);
    chk(glide_on, 1'b1);
    chk(lo_code, 7'h29);
    key(4'h7, 3'h0, 1'b1);
    chk(mono, 1'b0);
    to_lower <= 1'b0;
    key(4'h4, 3'h2, 1'b1);
    chk(busy, 1'b1);
    chk(up_code, 7'h1d);
    glide(7'h1d, 7'h22);
    key(4'h3, 3'h1, 1'b1);
    glide(7'h22, 7'h19);
    chk(done_count[7:0], 8'h02);
    key(4'h5, 3'h6, 1'b1);
    pulse();
    chk(up_code, 7'h1a);
    clear <= 1'b1;
    repeat (8) @(posedge i_mclk);
    clear <= 1'b0;
    repeat (8) @(posedge i_mclk);
    chk(up_code, 7'h2e);
    chk(busy, 1'b0);
    pulse();
    chk(up_code, 7'h2e);
    results();
  end
  initial begin
    repeat (5000) @(posedge i_mclk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end
endmodule : tb_glissando_key_code_stepper
bind glissando_key_code_stepper glissando_key_code_stepper_chk u_chk (
  .i_mclk, .i_sys_rst, .i_upper_key_on, .i_lower_key_on, .i_open_hold_setting,
  .o_upper_code, .o_lower_code, .o_upper_octave_tap, .o_upper_note_tap,
  .o_upper_hold_gate, .o_lower_hold_gate, .o_glide_busy, .o_glide_done, .o_portamento_on);
`default_nettype wire
